// ### flash_query_info_table.sv
// Purpose: Query information table read port of the flash
// Assumes: Requests come from logic on mclk_in; boot strap is a static pin
// Notes: Answer is registered, one cycle after the strobe
`timescale 1ns/1ps
module flash_query_info_table #(
  parameter bit BOTTOM_BOOT_DEFAULT = 1'b1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Mode
  input wire logic query_mode_in,
  input wire logic boot_strap_in,
  // Read request
  input wire query_table_pkg::read_req_type req_in,
  // Read answer
  output query_table_pkg::read_resp_type resp_out,
  output logic bad_addr_out
);

  logic strap_meta_reg;
  logic strap_sync_reg;
  logic bottom_boot_reg;
  logic [7:0] word_addr;
  logic addr_odd;
  logic [15:0] rom_data;
  query_table_pkg::read_resp_type resp_next;

  // Strap crosses in from a pin, so two stages before use
  // Stages start at the default so the boot bit cannot dip after reset
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_meta_reg <= BOTTOM_BOOT_DEFAULT;
      strap_sync_reg <= BOTTOM_BOOT_DEFAULT;
    end else begin
      strap_meta_reg <= boot_strap_in;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Boot placement held; default until the strap is synchronised
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bottom_boot_reg <= BOTTOM_BOOT_DEFAULT;
    end else begin
      bottom_boot_reg <= strap_sync_reg;
    end
  end

  // Byte mode drops the lane bit; odd byte addresses are flagged bad and read zero
  always_comb begin
    if (req_in.byte_mode) begin
      word_addr = req_in.addr[8:1];
      addr_odd = req_in.addr[0];
    end else begin
      word_addr = req_in.addr[7:0];
      addr_odd = req_in.addr[8];
    end
  end

  query_rom u_rom (
    .word_addr_in(word_addr),
    .bottom_boot_in(bottom_boot_reg),
    .data_out(rom_data)
  );

  always_comb begin
    resp_next.valid = req_in.strobe;
    resp_next.data = query_table_pkg::DATA_ZERO;
    if (req_in.strobe && query_mode_in && !addr_odd) begin
      resp_next.data = rom_data;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_out <= '0;
      bad_addr_out <= 1'b0;
    end else begin
      resp_out <= resp_next;
      bad_addr_out <= req_in.strobe && (addr_odd || !query_mode_in);
    end
  end

  // Checks
  a_typ_prog_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h01F)
    |=> resp_out.valid && resp_out.data == 16'h0004)
    else $error("typical program time wrong");
  a_typ_prog_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h03E)
    |=> resp_out.valid && resp_out.data == 16'h0004)
    else $error("typical program time wrong in byte mode");
  a_sect_erase_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h042)
    |=> resp_out.data == 16'h000A)
    else $error("typical sector erase wrong");
  a_sect_erase_word: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h021)
    |=> resp_out.data == 16'h000A)
    else $error("typical sector erase wrong in word mode");
  a_chip_erase_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h022)
    |=> resp_out.data == 16'h0010)
    else $error("typical chip erase wrong");
  a_chip_erase_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h044)
    |=> resp_out.data == 16'h0010)
    else $error("typical chip erase wrong in byte mode");
  a_max_prog_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h046)
    |=> resp_out.data == 16'h0004)
    else $error("program factor wrong");
  a_max_prog_word: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h023)
    |=> resp_out.data == 16'h0004)
    else $error("program factor wrong in word mode");
  a_max_sect_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h04A)
    |=> resp_out.data == 16'h0002)
    else $error("sector factor wrong");
  a_max_sect_word: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h025)
    |=> resp_out.data == 16'h0002)
    else $error("sector factor wrong in word mode");
  a_max_chip_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h026)
    |=> resp_out.data == 16'h0002)
    else $error("chip factor wrong");
  a_max_chip_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h04C)
    |=> resp_out.data == 16'h0002)
    else $error("chip factor wrong in byte mode");
  a_no_buffer_words: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && !req_in.byte_mode && (req_in.addr == 9'h02A || req_in.addr == 9'h02B))
    |=> resp_out.valid && resp_out.data == 16'h0000)
    else $error("buffer words not zero");
  a_no_buffer_bytes: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode
     && (req_in.addr == 9'h054 || req_in.addr == 9'h056))
    |=> resp_out.valid && !bad_addr_out && resp_out.data == 16'h0000)
    else $error("buffer bytes not zero");
  a_major_version: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h088)
    |=> resp_out.data == 16'h0031)
    else $error("major version wrong");
  a_major_word: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h044)
    |=> resp_out.data == 16'h0031)
    else $error("major version wrong in word mode");
  a_minor_version: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h045)
    |=> resp_out.data == 16'h0030)
    else $error("minor version wrong");
  a_minor_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h08A)
    |=> resp_out.data == 16'h0030)
    else $error("minor version wrong in byte mode");
  a_feature_word: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h046)
    |=> resp_out.data == 16'h0087)
    else $error("feature word wrong");
  a_feature_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h08C)
    |=> resp_out.data == 16'h0087)
    else $error("feature word wrong in byte mode");
  a_boot_placement: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h047)
    |=> resp_out.data[15:1] == 15'h0000 && resp_out.data[0] == $past(bottom_boot_reg))
    else $error("boot placement wrong");
  a_boot_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h08E)
    |=> resp_out.data == {15'h0000, $past(bottom_boot_reg)})
    else $error("boot placement wrong in byte mode");
  a_burst_caps: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && !req_in.byte_mode && req_in.addr == 9'h048)
    |=> resp_out.data[15:3] == 13'h0000)
    else $error("burst undefined bits set");
  a_burst_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h090)
    |=> resp_out.valid && !bad_addr_out && resp_out.data[15:3] == 13'h0000)
    else $error("burst undefined bits set in byte mode");
  a_page_caps: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && req_in.byte_mode && req_in.addr == 9'h092)
    |=> resp_out.data == 16'h0000)
    else $error("page caps wrong");
  a_page_word: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h049)
    |=> resp_out.valid && !bad_addr_out && resp_out.data == 16'h0000)
    else $error("page caps wrong in word mode");
  a_lock_location: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && req_in.addr == 9'h094)
    |=> resp_out.data == 16'h0080)
    else $error("lock location wrong");
  a_lock_word: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h04A)
    |=> resp_out.data == 16'h0080)
    else $error("lock location wrong in word mode");
  a_prot_exponents: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode
     && (req_in.addr == 9'h04B || req_in.addr == 9'h04C))
    |=> resp_out.data == 16'h0003)
    else $error("protection exponent wrong");
  a_prot_bytes: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode
     && (req_in.addr == 9'h096 || req_in.addr == 9'h098))
    |=> resp_out.data == 16'h0003)
    else $error("protection exponent wrong in byte mode");
  a_mode_same_data: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && req_in.byte_mode && !req_in.addr[0])
    ##1 (req_in.strobe && query_mode_in && !req_in.byte_mode
         && req_in.addr == {1'b0, $past(req_in.addr[8:1])})
    |=> resp_out.data == $past(resp_out.data))
    else $error("byte and word data differ");
  a_odd_byte_refused: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && req_in.byte_mode && req_in.addr[0])
    |=> resp_out.valid && bad_addr_out && resp_out.data == 16'h0000)
    else $error("odd byte address not refused");
  a_word_high_refused: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && !req_in.byte_mode && req_in.addr[8])
    |=> resp_out.valid && bad_addr_out && resp_out.data == 16'h0000)
    else $error("word address above range not refused");
  a_mode_refused: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && !query_mode_in)
    |=> resp_out.valid && bad_addr_out && resp_out.data == 16'h0000)
    else $error("read outside query mode not refused");
  a_answer_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
    req_in.strobe |=> resp_out.valid)
    else $error("answer valid missing");
  a_idle_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
    !req_in.strobe |=> !resp_out.valid && !bad_addr_out && resp_out.data == 16'h0000)
    else $error("answer without request");
  a_query_string: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h010)
    |=> resp_out.data == 16'h0051)
    else $error("query string wrong");
  a_query_tail: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h012)
    |=> resp_out.data == 16'h0059)
    else $error("query string tail wrong");
  a_ext_string: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h041)
    |=> resp_out.data == 16'h0050)
    else $error("extended table string wrong");
  a_region_count: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode && req_in.addr == 9'h02D)
    |=> resp_out.data == 16'h001E)
    else $error("region count wrong");
  a_small_region: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_in.strobe && query_mode_in && !req_in.byte_mode
     && (req_in.addr == 9'h031 || req_in.addr == 9'h033))
    |=> resp_out.data == (req_in.addr == 9'h031 ? 16'h0020 : 16'h0007)
        || resp_out.data == ($past(req_in.addr) == 9'h031 ? 16'h0007 : 16'h0020))
    else $error("small region fields wrong");

endmodule

// ### query_table_pkg.sv
// Purpose: Constants and carriers for the flash query information table
// Assumes: Word addresses as seen in 16-bit operation
// Notes: Byte mode addresses are twice the word addresses
package query_table_pkg;

  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 16;

  // Identification strings
  localparam logic [7:0] WA_ID_Q = 8'h10;
  localparam logic [7:0] WA_ID_R = 8'h11;
  localparam logic [7:0] WA_ID_Y = 8'h12;
  localparam logic [15:0] ID_Q = 16'h0051;
  localparam logic [15:0] ID_R = 16'h0052;
  localparam logic [15:0] ID_Y = 16'h0059;
  localparam logic [7:0] WA_CMDSET_LO = 8'h13;
  localparam logic [15:0] CMDSET_LO = 16'h0002;
  localparam logic [7:0] WA_EXT_LO = 8'h15;
  localparam logic [15:0] EXT_LO = 16'h0041;

  // Voltage fields
  localparam logic [7:0] WA_VCC_MIN = 8'h1B;
  localparam logic [15:0] VCC_MIN = 16'h0027;
  localparam logic [7:0] WA_VCC_MAX = 8'h1C;
  localparam logic [15:0] VCC_MAX = 16'h0036;
  localparam logic [7:0] WA_VPP_MIN = 8'h1D;
  localparam logic [15:0] VPP_MIN = 16'h00B5;
  localparam logic [7:0] WA_VPP_MAX = 8'h1E;
  localparam logic [15:0] VPP_MAX = 16'h00C5;

  // Timing fields
  localparam logic [7:0] WA_TYP_PROG = 8'h1F;
  localparam logic [15:0] TYP_PROG = 16'h0004;
  localparam logic [7:0] WA_TYP_SECT = 8'h21;
  localparam logic [15:0] TYP_SECT = 16'h000A;
  localparam logic [7:0] WA_TYP_CHIP = 8'h22;
  localparam logic [15:0] TYP_CHIP = 16'h0010;
  localparam logic [7:0] WA_MAX_PROG = 8'h23;
  localparam logic [15:0] MAX_PROG = 16'h0004;
  localparam logic [7:0] WA_MAX_SECT = 8'h25;
  localparam logic [15:0] MAX_SECT = 16'h0002;
  localparam logic [7:0] WA_MAX_CHIP = 8'h26;
  localparam logic [15:0] MAX_CHIP = 16'h0002;

  // Geometry
  localparam logic [7:0] WA_DEV_SIZE = 8'h27;
  localparam logic [15:0] DEV_SIZE = 16'h0015;
  localparam logic [7:0] WA_IFACE = 8'h28;
  localparam logic [15:0] IFACE = 16'h0002;
  localparam logic [7:0] WA_BUF_LO = 8'h2A;
  localparam logic [7:0] WA_BUF_HI = 8'h2B;
  localparam logic [15:0] BUF_NONE = 16'h0000;
  localparam logic [7:0] WA_REGIONS = 8'h2C;
  localparam logic [15:0] REGIONS = 16'h0002;
  localparam logic [7:0] WA_R0_CNT = 8'h2D;
  localparam logic [15:0] R0_CNT = 16'h001E;
  localparam logic [7:0] WA_R0_SIZE_HI = 8'h30;
  localparam logic [15:0] R0_SIZE_HI = 16'h0001;
  localparam logic [7:0] WA_R1_CNT = 8'h31;
  localparam logic [15:0] R1_CNT = 16'h0007;
  localparam logic [7:0] WA_R1_SIZE_LO = 8'h33;
  localparam logic [15:0] R1_SIZE_LO = 16'h0020;

  // Vendor extended table
  localparam logic [7:0] WA_PRI_P = 8'h41;
  localparam logic [7:0] WA_PRI_R = 8'h42;
  localparam logic [7:0] WA_PRI_I = 8'h43;
  localparam logic [15:0] PRI_P = 16'h0050;
  localparam logic [15:0] PRI_R = 16'h0052;
  localparam logic [15:0] PRI_I = 16'h0049;
  localparam logic [7:0] WA_VER_MAJ = 8'h44;
  localparam logic [15:0] VER_MAJ = 16'h0031;
  localparam logic [7:0] WA_VER_MIN = 8'h45;
  localparam logic [15:0] VER_MIN = 16'h0030;
  localparam logic [7:0] WA_FEATURES = 8'h46;
  localparam logic [15:0] FEATURES = 16'h0087;
  localparam logic [7:0] WA_BOOT = 8'h47;
  localparam int BOOT_BIT = 0;
  localparam logic [7:0] WA_BURST = 8'h48;
  localparam logic [2:0] BURST_CAPS = 3'h0;
  localparam logic [7:0] WA_PAGE = 8'h49;
  localparam logic [15:0] PAGE_CAPS = 16'h0000;
  localparam logic [7:0] WA_PROT_LOCK = 8'h4A;
  localparam logic [15:0] PROT_LOCK = 16'h0080;
  localparam logic [7:0] WA_PROT_FACT = 8'h4B;
  localparam logic [7:0] WA_PROT_USER = 8'h4C;
  localparam logic [15:0] PROT_EXP = 16'h0003;

  localparam logic [15:0] DATA_ZERO = 16'h0000;

  // Read request carrier
  typedef struct packed {
    logic strobe;
    logic byte_mode;
    logic [ADDR_WIDTH:0] addr;
  } read_req_type;

  // Read answer carrier
  typedef struct packed {
    logic valid;
    logic [DATA_WIDTH-1:0] data;
  } read_resp_type;

endpackage

// ### query_rom.sv
// Purpose: Combinational lookup of the query table by word address
// Assumes: Address already reduced to word form
// Notes: Unlisted addresses read zero
`timescale 1ns/1ps
module query_rom (
  // Lookup
  input wire logic [7:0] word_addr_in,
  input wire logic bottom_boot_in,
  output logic [15:0] data_out
);

  always_comb begin
    case (word_addr_in)
      query_table_pkg::WA_ID_Q: data_out = query_table_pkg::ID_Q;
      query_table_pkg::WA_ID_R: data_out = query_table_pkg::ID_R;
      query_table_pkg::WA_ID_Y: data_out = query_table_pkg::ID_Y;
      query_table_pkg::WA_CMDSET_LO: data_out = query_table_pkg::CMDSET_LO;
      query_table_pkg::WA_EXT_LO: data_out = query_table_pkg::EXT_LO;
      query_table_pkg::WA_VCC_MIN: data_out = query_table_pkg::VCC_MIN;
      query_table_pkg::WA_VCC_MAX: data_out = query_table_pkg::VCC_MAX;
      query_table_pkg::WA_VPP_MIN: data_out = query_table_pkg::VPP_MIN;
      query_table_pkg::WA_VPP_MAX: data_out = query_table_pkg::VPP_MAX;
      query_table_pkg::WA_TYP_PROG: data_out = query_table_pkg::TYP_PROG;
      query_table_pkg::WA_TYP_SECT: data_out = query_table_pkg::TYP_SECT;
      query_table_pkg::WA_TYP_CHIP: data_out = query_table_pkg::TYP_CHIP;
      query_table_pkg::WA_MAX_PROG: data_out = query_table_pkg::MAX_PROG;
      query_table_pkg::WA_MAX_SECT: data_out = query_table_pkg::MAX_SECT;
      query_table_pkg::WA_MAX_CHIP: data_out = query_table_pkg::MAX_CHIP;
      query_table_pkg::WA_DEV_SIZE: data_out = query_table_pkg::DEV_SIZE;
      query_table_pkg::WA_IFACE: data_out = query_table_pkg::IFACE;
      query_table_pkg::WA_BUF_LO: data_out = query_table_pkg::BUF_NONE;
      query_table_pkg::WA_BUF_HI: data_out = query_table_pkg::BUF_NONE;
      query_table_pkg::WA_REGIONS: data_out = query_table_pkg::REGIONS;
      query_table_pkg::WA_R0_CNT: data_out = query_table_pkg::R0_CNT;
      query_table_pkg::WA_R0_SIZE_HI: data_out = query_table_pkg::R0_SIZE_HI;
      query_table_pkg::WA_R1_CNT: data_out = query_table_pkg::R1_CNT;
      query_table_pkg::WA_R1_SIZE_LO: data_out = query_table_pkg::R1_SIZE_LO;
      query_table_pkg::WA_PRI_P: data_out = query_table_pkg::PRI_P;
      query_table_pkg::WA_PRI_R: data_out = query_table_pkg::PRI_R;
      query_table_pkg::WA_PRI_I: data_out = query_table_pkg::PRI_I;
      query_table_pkg::WA_VER_MAJ: data_out = query_table_pkg::VER_MAJ;
      query_table_pkg::WA_VER_MIN: data_out = query_table_pkg::VER_MIN;
      query_table_pkg::WA_FEATURES: data_out = query_table_pkg::FEATURES;
      query_table_pkg::WA_BOOT: data_out = {15'h0000, bottom_boot_in};
      query_table_pkg::WA_BURST: data_out = {13'h0000, query_table_pkg::BURST_CAPS};
      query_table_pkg::WA_PAGE: data_out = query_table_pkg::PAGE_CAPS;
      query_table_pkg::WA_PROT_LOCK: data_out = query_table_pkg::PROT_LOCK;
      query_table_pkg::WA_PROT_FACT: data_out = query_table_pkg::PROT_EXP;
      query_table_pkg::WA_PROT_USER: data_out = query_table_pkg::PROT_EXP;
      default: data_out = query_table_pkg::DATA_ZERO;
    endcase
  end

endmodule

// ### query_host_model.sv
// Purpose: Host bus master model reading the query table
// Assumes: Bench changes go and address on the falling edge
// Notes: Idle address lines show the inverted last value, not a held copy
`timescale 1ns/1ps
module query_host_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Command from bench
  input wire logic go_in,
  input wire logic byte_mode_in,
  input wire logic [8:0] addr_in,
  // Bus to table
  output query_table_pkg::read_req_type req_out,
  input wire query_table_pkg::read_resp_type resp_in,
  input wire logic bad_addr_in,
  // Captured answer
  output logic done_out,
  output logic bad_out,
  output logic [15:0] data_out
);
  initial req_out = '0;

  // Launch one cycle after go; a held go gives back-to-back strobes
  always @(negedge mclk_in) begin
    if (go_in) begin
      req_out <= '{strobe: 1'b1, byte_mode: byte_mode_in, addr: addr_in};
    end else begin
      req_out <= '{strobe: 1'b0, byte_mode: ~req_out.byte_mode, addr: ~req_out.addr};
    end
  end

  // Answer registered every cycle; done_out marks its single valid cycle
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      bad_out <= 1'b0;
      data_out <= 16'h0000;
    end else begin
      done_out <= resp_in.valid;
      bad_out <= bad_addr_in;
      data_out <= resp_in.data;
    end
  end
endmodule

// ### test_flash_query_info_table.sv
// Purpose: Self-checking bench for the query information table
// Assumes: Host model launches reads; answers return in issue order
// Notes: Boot strap settles over three edges, so reads wait after changes
`timescale 1ns/1ps
module test_flash_query_info_table;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic query_mode_in = 1'b1;
  logic boot_strap_in = 1'b1;
  logic go = 1'b0;
  logic bm = 1'b0;
  logic [8:0] addr = 9'h000;
  query_table_pkg::read_req_type req;
  query_table_pkg::read_resp_type resp;
  logic bad_addr;
  logic done;
  logic host_bad;
  logic [15:0] host_data;
  logic [16:0] exp_now;
  logic [16:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  // Word address beside the data it must give
  localparam logic [23:0] ROWS [31] = '{
    24'h100051, 24'h110052, 24'h120059,
    24'h1F0004, 24'h21000A, 24'h220010, 24'h230004, 24'h250002, 24'h260002,
    24'h2A0000, 24'h2B0000,
    24'h2C0002, 24'h2D001E, 24'h2E0000, 24'h2F0000, 24'h300001,
    24'h310007, 24'h320000, 24'h330020, 24'h340000,
    24'h410050, 24'h420052, 24'h430049, 24'h440031, 24'h450030,
    24'h460087, 24'h480000, 24'h490000, 24'h4A0080,
    24'h4B0003, 24'h4C0003};

  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  flash_query_info_table DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .query_mode_in(query_mode_in),
    .boot_strap_in(boot_strap_in), .req_in(req), .resp_out(resp), .bad_addr_out(bad_addr));

  query_host_model host (
    .mclk_in(mclk_in), .rst_in(rst_in), .go_in(go), .byte_mode_in(bm), .addr_in(addr),
    .req_out(req), .resp_in(resp), .bad_addr_in(bad_addr), .done_out(done),
    .bad_out(host_bad), .data_out(host_data));

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic issue(input logic [8:0] a, input logic b, input logic [16:0] e);
    @(negedge mclk_in);
    go <= 1'b1;
    addr <= a;
    bm <= b;
    exp_q.push_back(e);
  endtask

  task automatic settle(input string name);
    @(negedge mclk_in);
    go <= 1'b0;
    repeat (4) @(negedge mclk_in);
    check("reads left unanswered", 16'h0000, 16'(exp_q.size()));
    $display("test done: %s", name);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Answers compared in order; one with nothing pending is spurious
  always @(negedge mclk_in) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spurious answer", 16'h0000, 16'h0001);
      end else begin
        exp_now = exp_q.pop_front();
        check("read data", exp_now[15:0], host_data);
        check("bad address flag", {15'h0000, exp_now[16]}, {15'h0000, host_bad});
      end
    end
  end

  // Whole run is under 130 cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      $display("timeout after %0d cycles", cycles);
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    repeat (4) @(posedge mclk_in);
    check("valid in reset", 16'h0000, {15'h0000, resp.valid});
    check("data in reset", 16'h0000, resp.data);
    $display("test done: reset values");
    @(negedge mclk_in);
    rst_in <= 1'b0;
    // Byte read first, so each row hands a byte then word pair to the checks
    for (int i = 0; i < 31; i++) begin
      issue({ROWS[i][23:16], 1'b0}, 1'b1, {1'b0, ROWS[i][15:0]});
      issue({1'b0, ROWS[i][23:16]}, 1'b0, {1'b0, ROWS[i][15:0]});
    end
    settle("table rows");
    issue(9'h047, 1'b0, 17'h00001);
    issue(9'h08E, 1'b1, 17'h00001);
    settle("bottom boot");
    boot_strap_in <= 1'b0;
    repeat (4) @(negedge mclk_in);
    issue(9'h047, 1'b0, 17'h00000);
    issue(9'h08E, 1'b1, 17'h00000);
    settle("top boot");
    issue(9'h03F, 1'b1, 17'h10000);
    issue(9'h11F, 1'b0, 17'h10000);
    issue(9'h060, 1'b0, 17'h00000);
    issue(9'h0C0, 1'b1, 17'h00000);
    issue(9'h048, 1'b0, 17'h00000);
    settle("refused and unlisted");
    query_mode_in <= 1'b0;
    issue(9'h01F, 1'b0, 17'h10000);
    issue(9'h03E, 1'b1, 17'h10000);
    settle("outside query mode");
    query_mode_in <= 1'b1;
    issue(9'h01F, 1'b0, 17'h00004);
    settle("query mode again");
    @(negedge mclk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    check("valid in second reset", 16'h0000, {15'h0000, resp.valid});
    check("flag in second reset", 16'h0000, {15'h0000, bad_addr});
    @(negedge mclk_in);
    rst_in <= 1'b0;
    issue(9'h044, 1'b0, 17'h00031);
    issue(9'h08A, 1'b1, 17'h00030);
    settle("after second reset");
    report_and_stop();
  end
endmodule
